// file: design/host_indirect_access_regs.sv
// Device end: host register group with chip soft reset, status, interrupt
// and the indirect memory access engine.
// Assumes the memory side answers each request with a one-cycle memAck.
`timescale 1ns/1ps

module host_indirect_access_regs (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Register bus
  host_bus_if.device       bus,
  // Internal module service requests
  input  wire logic [7:0]  moduleSrv,
  // Chip soft reset to the rest of the device
  output logic             chipReset,
  // Indirect memory port
  output logic             memReq,
  output logic             memWrite,
  output logic             memExt,
  output logic [20:0]      memAddr,
  output logic [15:0]      memWdata,
  input  wire logic [15:0] memRdata,
  input  wire logic        memAck
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [0:0] {ENG_IDLE, ENG_BUSY} eng_state_e;

  logic [15:1] lowAddress;      // Byte address bits 15:1
  logic [4:0]  highAddress;     // Byte address bits 20:16
  logic        extSelect;       // External memory select
  logic        dirRead;         // Direction, 1 = read
  logic        accessBusy;      // Access in progress
  logic        doneEnable;      // Completion request enable
  logic [15:0] indirectData;    // Indirect data value
  logic [8:0]  intEnable;       // Interrupt enable mask
  logic [8:0]  serviceFlags;    // Main status flags
  logic [15:0] next_rdata;      // Read mux output
  eng_state_e  engState;        // Indirect engine state
  logic        wrLow;           // Decoded writes
  logic        wrHigh;
  logic        wrData;
  logic        startCycle;      // Host asks for a new indirect cycle
  logic        cycleDone;       // Memory side has answered

  // Address match for a write
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wrLow      = bus.wrStb && hit(bus.addr, host_regs_pkg::OFS_LOW_ADDRESS);
  assign wrHigh     = bus.wrStb && hit(bus.addr, host_regs_pkg::OFS_HIGH_ADDR_CMD);
  assign wrData     = bus.wrStb && hit(bus.addr, host_regs_pkg::OFS_INDIRECT_DATA);
  // A set of the busy bit while already busy is ignored
  assign startCycle = wrHigh && bus.wdata[host_regs_pkg::BIT_ACCESS] && !accessBusy;
  assign cycleDone  = (engState == ENG_BUSY) && memAck;

  // ****************************************
  // Chip soft reset
  // ****************************************
  // This register ignores the bit, as do all but the module flags, so software can always release it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chipReset <= host_regs_pkg::RST_CHIP_SOFT_RESET[host_regs_pkg::BIT_RESET];
    end else if (bus.wrStb && hit(bus.addr, host_regs_pkg::OFS_CHIP_SOFT_RESET)) begin
      chipReset <= bus.wdata[host_regs_pkg::BIT_RESET];
    end
  end

  // ****************************************
  // Address and command fields
  // ****************************************
  // Fields stay writable while busy; the engine uses its latched copy
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lowAddress  <= '0;
      highAddress <= '0;
      extSelect   <= 1'b0;
      dirRead     <= 1'b0;
      doneEnable  <= 1'b0;
    end else begin
      if (wrLow) begin
        lowAddress <= bus.wdata[15:1];
      end
      if (wrHigh) begin
        highAddress <= bus.wdata[host_regs_pkg::HI_ADDR_LSB +: host_regs_pkg::HI_ADDR_W];
        extSelect   <= bus.wdata[host_regs_pkg::BIT_EXT_MEM];
        dirRead     <= bus.wdata[host_regs_pkg::BIT_DIR_READ];
        doneEnable  <= bus.wdata[host_regs_pkg::BIT_DONE_EN];
      end
    end
  end

  // ****************************************
  // Busy bit and indirect engine
  // ****************************************
  // Busy clears only on completion; writing zero to it has no effect
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      accessBusy <= 1'b0;
      engState   <= ENG_IDLE;
    end else begin
      case (engState)
        ENG_IDLE: begin
          if (startCycle) begin
            accessBusy <= 1'b1;
            engState   <= ENG_BUSY;
          end
        end
        ENG_BUSY: begin
          if (memAck) begin
            accessBusy <= 1'b0;
            engState   <= ENG_IDLE;
          end
        end
        default: begin
          accessBusy <= 1'b0;
          engState   <= ENG_IDLE;
        end
      endcase
    end
  end

  // Memory request, with target captured from the live fields at start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      memReq   <= 1'b0;
      memWrite <= 1'b0;
      memExt   <= 1'b0;
      memAddr  <= '0;
      memWdata <= '0;
    end else if (startCycle) begin
      memReq   <= 1'b1;
      // Takes the fields being written in this same cycle
      memWrite <= !bus.wdata[host_regs_pkg::BIT_DIR_READ];
      memExt   <= bus.wdata[host_regs_pkg::BIT_EXT_MEM];
      memAddr  <= {bus.wdata[host_regs_pkg::HI_ADDR_LSB +: host_regs_pkg::HI_ADDR_W],
                   lowAddress, 1'b0};
      memWdata <= indirectData;
    end else if (cycleDone) begin
      memReq   <= 1'b0;
    end
  end

  // ****************************************
  // Indirect data register
  // ****************************************
  // Completion of a read wins over a host write in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      indirectData <= host_regs_pkg::RST_ZERO;
    end else if (cycleDone && !memWrite) begin
      indirectData <= memRdata;
    end else if (wrData) begin
      indirectData <= bus.wdata;
    end
  end

  // ****************************************
  // Interrupt enable mask
  // ****************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      intEnable <= host_regs_pkg::RST_ZERO[8:0];
    end else if (bus.wrStb && hit(bus.addr, host_regs_pkg::OFS_INT_ENABLE_MASK)) begin
      intEnable <= bus.wdata[8:0];
    end
  end

  // ****************************************
  // Service flags and interrupt
  // ****************************************
  // Module flags are forced low while those modules sit in reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serviceFlags <= host_regs_pkg::RST_ZERO[8:0];
    end else begin
      serviceFlags[7:0] <= chipReset ? 8'h00 : moduleSrv;
      serviceFlags[host_regs_pkg::BIT_HOST_SRV] <= doneEnable && !accessBusy;
    end
  end

  // Registered level, one cycle behind the flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus.irqN <= 1'b1;
    end else begin
      bus.irqN <= !(|(serviceFlags & intEnable));
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Every register stays readable during a busy cycle
  always_comb begin
    next_rdata = host_regs_pkg::RST_ZERO;
    case (bus.addr)
      host_regs_pkg::OFS_CHIP_SOFT_RESET: next_rdata[host_regs_pkg::BIT_RESET] = chipReset;
      host_regs_pkg::OFS_MAIN_STATUS:     next_rdata[8:0] = serviceFlags;
      host_regs_pkg::OFS_LOW_ADDRESS:     next_rdata[15:1] = lowAddress;
      host_regs_pkg::OFS_HIGH_ADDR_CMD: begin
        next_rdata[host_regs_pkg::HI_ADDR_LSB +: host_regs_pkg::HI_ADDR_W] = highAddress;
        next_rdata[host_regs_pkg::BIT_EXT_MEM]  = extSelect;
        next_rdata[host_regs_pkg::BIT_DIR_READ] = dirRead;
        next_rdata[host_regs_pkg::BIT_ACCESS]   = accessBusy;
        next_rdata[host_regs_pkg::BIT_DONE_EN]  = doneEnable;
      end
      host_regs_pkg::OFS_INDIRECT_DATA:   next_rdata = indirectData;
      host_regs_pkg::OFS_INT_ENABLE_MASK: next_rdata[8:0] = intEnable;
      default:                            next_rdata = host_regs_pkg::RST_ZERO;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus.rdata <= host_regs_pkg::RST_ZERO;
    end else if (bus.rdStb) begin
      bus.rdata <= next_rdata;
    end else begin
      bus.rdata <= host_regs_pkg::RST_ZERO;
    end
  end

endmodule

// file: design/host_regs_pkg.sv
// Shared constants for the host register group and its bus controller.
// Assumes a 16-bit word bus with byte addresses; all registers are word aligned.
package host_regs_pkg;

  // ****************************************
  // Bus widths
  // ****************************************
  localparam int ADDR_W   = 16;   // Register bus byte address width
  localparam int DATA_W   = 16;   // Register bus data width
  localparam int MADDR_W  = 21;   // Indirect byte address width
  localparam int SRV_W    = 9;    // Service request flags
  localparam int MOD_W    = 8;    // Flags fed by internal modules

  // ****************************************
  // Device register offsets
  // ****************************************
  localparam logic [15:0] OFS_CHIP_SOFT_RESET  = 16'h0000;
  localparam logic [15:0] OFS_MAIN_STATUS      = 16'h0002;
  localparam logic [15:0] OFS_LOW_ADDRESS      = 16'h0004;
  localparam logic [15:0] OFS_HIGH_ADDR_CMD    = 16'h0006;
  localparam logic [15:0] OFS_INDIRECT_DATA    = 16'h0008;
  localparam logic [15:0] OFS_INT_ENABLE_MASK  = 16'h000A;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_CHIP_SOFT_RESET  = 16'h0001;
  localparam logic [15:0] RST_ZERO             = 16'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_RESET      = 0;   // Chip soft reset bit
  localparam int HI_ADDR_LSB    = 0;   // High address field, bits 4:0
  localparam int HI_ADDR_W      = 5;
  localparam int BIT_EXT_MEM    = 5;   // External memory select
  localparam int BIT_DIR_READ   = 6;   // 1 = read, 0 = write
  localparam int BIT_ACCESS     = 7;   // Access in progress
  localparam int BIT_DONE_EN    = 8;   // Completion request enable
  localparam int BIT_HOST_SRV   = 8;   // Host interface request in status
  localparam int CMD_W          = 9;   // Writable bits of the command word

  // ****************************************
  // Controller register offsets (user side of the host end)
  // ****************************************
  localparam logic [3:0] CTL_ADDR_LO  = 4'h0;  // Byte address bits 15:0
  localparam logic [3:0] CTL_ADDR_HI  = 4'h2;  // Bits 4:0 addr, 5 ext, 6 read, 8 done enable
  localparam logic [3:0] CTL_DATA     = 4'h4;  // Write data in, read data out
  localparam logic [3:0] CTL_GO       = 4'h6;  // Write: bit0 go, bit1 reset write, bit2 value, bit3 mask
  localparam logic [3:0] CTL_STATUS   = 4'h8;  // Read: bit0 busy, bit1 irq seen

  localparam int CTL_BIT_GO     = 0;
  localparam int CTL_BIT_RSTWR  = 1;
  localparam int CTL_BIT_RSTVAL = 2;
  localparam int CTL_BIT_MASKWR = 3;   // Data register goes to the enable mask
  localparam int CTL_BIT_BUSY   = 0;
  localparam int CTL_BIT_IRQ    = 1;

endpackage

// file: design/host_bus_if.sv
// Parallel register bus between the host controller and the device register group.
// Assumes one clock for both ends; read data is valid the cycle after the read strobe.
`timescale 1ns/1ps

interface host_bus_if;
  logic [15:0] addr;    // Byte address
  logic [15:0] wdata;   // Write data
  logic        wrStb;   // One-cycle write strobe
  logic        rdStb;   // One-cycle read strobe
  logic [15:0] rdata;   // Read data, one cycle after rdStb
  logic        irqN;    // Interrupt, active low level

  // ****************************************
  // Modports
  // ****************************************
  modport device (input addr, input wdata, input wrStb, input rdStb,
                  output rdata, output irqN);
  modport host   (output addr, output wdata, output wrStb, output rdStb,
                  input rdata, input irqN);
endinterface

// file: design/host_access_controller.sv
// Host end: runs indirect accesses and chip reset writes on the register bus.
// Assumes user software drives a plain port: address, data, write and read strobes.
`timescale 1ns/1ps

module host_access_controller (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Register bus
  host_bus_if.host         bus,
  // User command port
  input  wire logic [3:0]  cmdAddr,
  input  wire logic [15:0] cmdWdata,
  input  wire logic        cmdWr,
  input  wire logic        cmdRd,
  output logic [15:0]      cmdRdata
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE, S_DATA, S_LOW, S_HIGH, S_POLL, S_PWAIT, S_CHECK, S_READ, S_RWAIT, S_TAKE
  } seq_state_e;

  seq_state_e  seqState;    // Sequencer state
  logic [15:0] addrLo;      // Target byte address bits 15:0
  logic [15:0] addrHi;      // Address high and command bits
  logic [15:0] dataReg;     // Write data, then read result
  logic [15:0] next_rdata;  // User read mux
  logic        busy;        // Sequence running
  logic        isRead;      // Current sequence reads
  logic        goCmd;       // User go write

  assign goCmd  = cmdWr && (cmdAddr == host_regs_pkg::CTL_GO)
                  && cmdWdata[host_regs_pkg::CTL_BIT_GO];
  assign busy   = (seqState != S_IDLE);
  assign isRead = addrHi[host_regs_pkg::BIT_DIR_READ];

  // ****************************************
  // User registers
  // ****************************************
  // Writes while busy are dropped so the running sequence stays coherent
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addrLo <= host_regs_pkg::RST_ZERO;
      addrHi <= host_regs_pkg::RST_ZERO;
    end else if (cmdWr && !busy) begin
      if (cmdAddr == host_regs_pkg::CTL_ADDR_LO) begin
        addrLo <= cmdWdata;
      end
      if (cmdAddr == host_regs_pkg::CTL_ADDR_HI) begin
        addrHi <= cmdWdata;
      end
    end
  end

  // Data register also takes the indirect read result
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dataReg <= host_regs_pkg::RST_ZERO;
    end else if (seqState == S_TAKE) begin
      dataReg <= bus.rdata;
    end else if (cmdWr && !busy && cmdAddr == host_regs_pkg::CTL_DATA) begin
      dataReg <= cmdWdata;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // At most one bus strobe per state; polling repeats until the device is idle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seqState  <= S_IDLE;
      bus.addr  <= host_regs_pkg::RST_ZERO;
      bus.wdata <= host_regs_pkg::RST_ZERO;
      bus.wrStb <= 1'b0;
      bus.rdStb <= 1'b0;
    end else begin
      bus.wrStb <= 1'b0;
      bus.rdStb <= 1'b0;
      case (seqState)
        S_IDLE: begin
          if (cmdWr && !busy && cmdAddr == host_regs_pkg::CTL_GO
              && cmdWdata[host_regs_pkg::CTL_BIT_RSTWR]) begin
            // Direct chip reset write, no indirect cycle
            bus.addr  <= host_regs_pkg::OFS_CHIP_SOFT_RESET;
            bus.wdata <= {15'h0000, cmdWdata[host_regs_pkg::CTL_BIT_RSTVAL]};
            bus.wrStb <= 1'b1;
          end else if (cmdWr && cmdAddr == host_regs_pkg::CTL_GO
                       && cmdWdata[host_regs_pkg::CTL_BIT_MASKWR]) begin
            // Interrupt enable mask taken from the data register
            bus.addr  <= host_regs_pkg::OFS_INT_ENABLE_MASK;
            bus.wdata <= dataReg;
            bus.wrStb <= 1'b1;
          end else if (goCmd) begin
            seqState <= isRead ? S_LOW : S_DATA;
          end
        end
        S_DATA: begin
          bus.addr  <= host_regs_pkg::OFS_INDIRECT_DATA;
          bus.wdata <= dataReg;
          bus.wrStb <= 1'b1;
          seqState  <= S_LOW;
        end
        S_LOW: begin
          bus.addr  <= host_regs_pkg::OFS_LOW_ADDRESS;
          bus.wdata <= {addrLo[15:1], 1'b0};
          bus.wrStb <= 1'b1;
          seqState  <= S_HIGH;
        end
        S_HIGH: begin
          bus.addr  <= host_regs_pkg::OFS_HIGH_ADDR_CMD;
          bus.wdata <= addrHi | (16'h0001 << host_regs_pkg::BIT_ACCESS);
          bus.wrStb <= 1'b1;
          seqState  <= S_POLL;
        end
        S_POLL: begin
          bus.addr  <= host_regs_pkg::OFS_HIGH_ADDR_CMD;
          bus.rdStb <= 1'b1;
          seqState  <= S_PWAIT;
        end
        S_PWAIT: begin
          // Strobe cycle; the device answers in the next one
          seqState <= S_CHECK;
        end
        S_CHECK: begin
          // Read data of the poll stand in this cycle
          if (bus.rdata[host_regs_pkg::BIT_ACCESS]) begin
            seqState <= S_POLL;
          end else if (isRead) begin
            seqState <= S_READ;
          end else begin
            seqState <= S_IDLE;
          end
        end
        S_READ: begin
          bus.addr  <= host_regs_pkg::OFS_INDIRECT_DATA;
          bus.rdStb <= 1'b1;
          seqState  <= S_RWAIT;
        end
        S_RWAIT: begin
          // Strobe cycle; the data stand in the next one
          seqState <= S_TAKE;
        end
        S_TAKE: begin
          seqState <= S_IDLE;
        end
        default: begin
          seqState <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // User read path
  // ****************************************
  always_comb begin
    next_rdata = host_regs_pkg::RST_ZERO;
    case (cmdAddr)
      host_regs_pkg::CTL_ADDR_LO: next_rdata = addrLo;
      host_regs_pkg::CTL_ADDR_HI: next_rdata = addrHi;
      host_regs_pkg::CTL_DATA:    next_rdata = dataReg;
      host_regs_pkg::CTL_STATUS: begin
        next_rdata[host_regs_pkg::CTL_BIT_BUSY] = busy;
        next_rdata[host_regs_pkg::CTL_BIT_IRQ]  = !bus.irqN;
      end
      default:                    next_rdata = host_regs_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmdRdata <= host_regs_pkg::RST_ZERO;
    end else if (cmdRd) begin
      cmdRdata <= next_rdata;
    end else begin
      cmdRdata <= host_regs_pkg::RST_ZERO;
    end
  end

endmodule

// file: verif/host_bus_asserts.sv
// Checker for the register bus that joins the host end to the device end.
// Assumes one clock domain and that it sits beside the interface instance.
`timescale 1ns/1ps

module host_bus_asserts (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Bus signals
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [15:0] rdata,
  input wire logic        irqN
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ****************************************
  // Helper state
  // ****************************************
  logic maskWritten;  // Enable register touched since reset
  logic busyView;     // Host side belief that a cycle is running
  logic rdCmd;        // Previous cycle read the command register
  logic start;        // Command write that launches a cycle
  assign start = wrStb && addr == host_regs_pkg::OFS_HIGH_ADDR_CMD && wdata[7];

  // A poll that sees the busy bit low ends the host's wait; a start opens it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      maskWritten <= 1'b0;
      busyView    <= 1'b0;
      rdCmd       <= 1'b0;
    end else begin
      rdCmd <= rdStb && addr == host_regs_pkg::OFS_HIGH_ADDR_CMD;
      if (wrStb && addr == host_regs_pkg::OFS_INT_ENABLE_MASK) maskWritten <= 1'b1;
      if (start) busyView <= 1'b1;
      else if (rdCmd && !rdata[7]) busyView <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_strobes_exclusive: assert property (!(wrStb && rdStb))
    else $error("read and write strobes high together");
  a_rdata_idle_zero: assert property (!$past(rdStb) |-> rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_start_reads_busy: assert property (start ##2 rdCmd |-> rdata[7])
    else $error("busy bit not set after start");
  a_cmd_fields_back: assert property (start ##2 rdCmd |->
    rdata[6:0] == $past(wdata[6:0], 2) && rdata[15:9] == 7'h00)
    else $error("command fields read back wrong");
  a_low_before_high: assert property (start |->
    $past(wrStb) && $past(addr) == host_regs_pkg::OFS_LOW_ADDRESS)
    else $error("start without low address write just before");
  a_data_before_low: assert property (start && !wdata[6] |->
    $past(wrStb, 2) && $past(addr, 2) == host_regs_pkg::OFS_INDIRECT_DATA)
    else $error("write cycle started without data loaded first");
  a_wait_idle_first: assert property (
    (start || (wrStb && addr == host_regs_pkg::OFS_CHIP_SOFT_RESET)) |-> !busyView)
    else $error("new access while cycle still running");
  a_idle_before_data: assert property (
    rdStb && addr == host_regs_pkg::OFS_INDIRECT_DATA |-> !busyView || (rdCmd && !rdata[7]))
    else $error("data read before busy bit cleared");
  a_no_irq_unmasked: assert property (!maskWritten |-> irqN)
    else $error("interrupt with all enables clear");

  c_write_start: cover property (start && !wdata[6]);
  c_read_start: cover property (start && wdata[6]);
  c_reset_write: cover property (wrStb && addr == host_regs_pkg::OFS_CHIP_SOFT_RESET);
  c_data_read: cover property (rdStb && addr == host_regs_pkg::OFS_INDIRECT_DATA);
endmodule

// file: verif/host_indirect_access_regs_tb_top.sv
// Testbench joining host end and device end, with a small memory responder.
// Assumes the user port of the host end is the only software path.
`timescale 1ns/1ps

module host_indirect_access_regs_tb_top;
  logic        ref_clk, rstn, chipReset, memReq, memWrite, memExt, memAck;
  logic [7:0]  moduleSrv;
  logic [20:0] memAddr, lastAddr;
  logic [15:0] memWdata, memRdata, cmdWdata, cmdRdata;
  logic [15:0] memArr [0:31];  // Small memory, internal and external halves
  logic [3:0]  cmdAddr;
  logic        cmdWr, cmdRd, lastExt, lastWrite;
  logic [2:0]  ackDelay;       // Slow answer so polls see the engine busy
  int          compares, bad_count;

  host_bus_if i_host_bus_if ();
  host_indirect_access_regs i_host_indirect_access_regs (.ref_clk(ref_clk), .rstn(rstn),
    .bus(i_host_bus_if), .moduleSrv(moduleSrv), .chipReset(chipReset), .memReq(memReq),
    .memWrite(memWrite), .memExt(memExt), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck));
  host_access_controller i_host_access_controller (.ref_clk(ref_clk), .rstn(rstn),
    .bus(i_host_bus_if), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr),
    .cmdRd(cmdRd), .cmdRdata(cmdRdata));
  host_bus_asserts i_host_bus_asserts (.ref_clk(ref_clk), .rstn(rstn),
    .addr(i_host_bus_if.addr), .wdata(i_host_bus_if.wdata), .wrStb(i_host_bus_if.wrStb),
    .rdStb(i_host_bus_if.rdStb), .rdata(i_host_bus_if.rdata), .irqN(i_host_bus_if.irqN));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Memory answers after four cycles; idle read data is scrambled on purpose
  assign memRdata = memReq ? memArr[{memExt, memAddr[4:1]}] : ~memArr[{memExt, memAddr[4:1]}];
  always @(posedge ref_clk) begin
    memAck <= 1'b0;
    if (memReq && !memAck) begin
      ackDelay <= ackDelay + 3'd1;
      if (ackDelay == 3'd3) begin
        memAck    <= 1'b1;
        ackDelay  <= 3'd0;
        lastAddr  <= memAddr;
        lastExt   <= memExt;
        lastWrite <= memWrite;
        if (memWrite) memArr[{memExt, memAddr[4:1]}] <= memWdata;
      end
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic ctl_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    cmdAddr  <= a;
    cmdWdata <= d;
    cmdWr    <= 1'b1;
    @(posedge ref_clk);
    cmdWr <= 1'b0;
  endtask

  task automatic ctl_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    cmdAddr <= a;
    cmdRd   <= 1'b1;
    @(posedge ref_clk);
    cmdRd <= 1'b0;
    #1 d = cmdRdata;
  endtask

  // Bounded poll of the host end's busy flag
  task automatic wait_idle;
    logic [15:0] s;
    for (int i = 0; i < 100; i++) begin
      ctl_rd(host_regs_pkg::CTL_STATUS, s);
      if (s[host_regs_pkg::CTL_BIT_BUSY] === 1'b0) return;
    end
    bad_count++;
    tally_and_finish();
  endtask

  // Low address bit 0 is set on purpose: the host end must drop it
  task automatic run_access(input logic [20:0] a, input logic ext, input logic rd,
                            input logic [15:0] d);
    ctl_wr(host_regs_pkg::CTL_ADDR_LO, a[15:0] | 16'h0001);
    ctl_wr(host_regs_pkg::CTL_ADDR_HI, {9'h000, rd, ext, a[20:16]});
    ctl_wr(host_regs_pkg::CTL_DATA, d);
    ctl_wr(host_regs_pkg::CTL_GO, 16'h0001);
    wait_idle();
    check(lastAddr, {a[20:1], 1'b0});
    check(lastExt, ext);
    check(lastWrite, !rd);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    logic [15:0] vals [3] = '{16'h0002, 16'h0006, 16'h0002};
    check(chipReset, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ctl_wr(host_regs_pkg::CTL_GO, vals[i]);
      repeat (2) @(posedge ref_clk);
      #1 check(chipReset, vals[i][2]);
    end
    $display("test_reset done");
  endtask

  task automatic test_write;
    run_access(21'h1F_FFFE, 1'b1, 1'b0, 16'hA55A);
    check(memArr[5'h1F], 16'hA55A);
    run_access(21'h00_0002, 1'b0, 1'b0, 16'h0001);
    check(memArr[5'h01], 16'h0001);
    $display("test_write done");
  endtask

  task automatic test_read;
    logic [15:0] r;
    memArr[5'h13] = 16'hC3A5;
    run_access(21'h0A_5466, 1'b1, 1'b1, 16'h0000);
    ctl_rd(host_regs_pkg::CTL_DATA, r);
    check(r, 16'hC3A5);
    $display("test_read done");
  endtask

  // Irq-seen bit of the host end once the level has settled
  task automatic expect_irq(input logic e);
    logic [15:0] s;
    repeat (4) @(posedge ref_clk);
    ctl_rd(host_regs_pkg::CTL_STATUS, s);
    check(s[host_regs_pkg::CTL_BIT_IRQ], e);
  endtask

  // Module flags 0x5A against the mask, then the completion request
  task automatic test_irq;
    ctl_wr(host_regs_pkg::CTL_DATA, 16'h0001);
    ctl_wr(host_regs_pkg::CTL_GO, 16'h0008);
    expect_irq(1'b0);
    ctl_wr(host_regs_pkg::CTL_DATA, 16'h0002);
    ctl_wr(host_regs_pkg::CTL_GO, 16'h0008);
    expect_irq(1'b1);
    ctl_wr(host_regs_pkg::CTL_GO, 16'h0006);
    expect_irq(1'b0);
    ctl_wr(host_regs_pkg::CTL_GO, 16'h0002);
    ctl_wr(host_regs_pkg::CTL_DATA, 16'h0100);
    ctl_wr(host_regs_pkg::CTL_GO, 16'h0008);
    expect_irq(1'b0);
    ctl_wr(host_regs_pkg::CTL_ADDR_HI, 16'h0100);
    ctl_wr(host_regs_pkg::CTL_GO, 16'h0001);
    wait_idle();
    expect_irq(1'b1);
    $display("test_irq done");
  endtask

  initial begin
    rstn      = 1'b0;
    moduleSrv = 8'h5A;
    memAck    = 1'b0;
    ackDelay  = 3'd0;
    cmdAddr   = 4'h0;
    cmdWdata  = 16'h0000;
    cmdWr     = 1'b0;
    cmdRd     = 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    test_reset();
    test_write();
    test_read();
    test_irq();
    tally_and_finish();
  end
endmodule
